/* File: hw/frx_pkg.sv */
/*
 Constants for the file-register operation datapath: opcode prefixes,
 field positions, flag positions, reset values and the index of the last cycle phase.
 Assumes a single core clock; each instruction cycle is four clocks.
*/
// What this block does
// - Decode copy-register word, prefix then target bit then 7-bit address.
// - Copy updates zero flag; target bit 1 rewrites register, a test.
// - Subtract computes register minus accumulator, two's complement, to selected target.
// - Subtract carry set if no borrow; half-borrow and zero flags updated.
// - Nibble exchange swaps register halves; status flags untouched.
// - Nibble exchange writes accumulator when target bit 0, register when 1.
// - Load-direction opcode copies accumulator to direction latch 5 to 7, flags untouched.
// - Direction latches also readable and writable through the direct side port (dir_sel, dir_we), not at file addresses.
// - One instruction cycle is exactly four oscillator clock periods.
package frx_pkg;
	// Opcode field layout
	localparam int OPC_HI = 13;
	localparam int OPC_LO = 8;
	localparam int DST_BIT = 7;
	localparam logic [5:0] OPC_COPY = 6'h08;
	localparam logic [5:0] OPC_SUB = 6'h02;
	localparam logic [5:0] OPC_SWAP = 6'h0E;
	// Load-direction word: 00 0000 0110 0fff
	localparam logic [10:0] DIRLD_PREFIX = 11'h00C;
	localparam logic [2:0] DIR_FIRST = 3'h5;
	localparam logic [2:0] DIR_LAST = 3'h7;
	localparam int DIR_COUNT = 3;
	// File-space addresses named for the direction latches, unused: the latches are not mapped into the file space
	localparam logic [6:0] DIR_ADDR_BASE = 7'h05;
	localparam logic [6:0] DIR_ADDR_OFS = 7'h00;
	// Flag positions in the status output
	localparam int FLG_C = 0;
	localparam int FLG_HB = 1;
	localparam int FLG_Z = 2;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam logic [2:0] FLAG_RESET = 3'h0;
	localparam logic [1:0] PHASES = 2'h3;
	typedef enum logic [1:0] {ST_FETCH, ST_READ, ST_EXEC, ST_WRITE} frx_phase_e;
endpackage

/* File: hw/frx_phase_gen.sv */
/*
 Quarter-cycle phase divider: one enable pulse per four core clocks.
 Assumes clk is the oscillator clock and rst is asynchronous, active high.
*/
module frx_phase_gen
(
	input wire logic clk,
	input wire logic rst,
	output logic [1:0] phase_ff,
	output logic cyc_end_ff
);
	// ==========================================
	// Phase counter
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			phase_ff <= 2'h0;
			cyc_end_ff <= 1'b0;
		end
		else
		begin
			phase_ff <= phase_ff + 2'h1;
			cyc_end_ff <= (phase_ff == frx_pkg::PHASES - 2'h1);
		end
	end
endmodule

/* File: hw/frx_datapath.sv */
/*
 Execution datapath for copy, subtract, nibble exchange and the legacy
 load-direction instruction, with accumulator, flags and direction latches.
 Assumes the fetch stage holds instr_word and the file read data steady
 for a whole instruction cycle; file write strobes one clock per cycle.
*/
module frx_datapath
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [13:0] instr_word,
	input wire logic instr_valid,
	output logic [6:0] file_addr_ff,
	input wire logic [7:0] file_rdata,
	output logic [7:0] file_wdata_ff,
	output logic file_we_ff,
	input wire logic [1:0] dir_sel,
	input wire logic dir_we,
	input wire logic [7:0] dir_wdata,
	output logic [7:0] dir_rdata_ff,
	output logic [7:0] acc_ff,
	output logic [2:0] flags_ff,
	output logic [23:0] dir_latch_ff,
	output logic cycle_done_ff
);
	// ==========================================
	// Phase sequencing
	logic [1:0] phase;
	logic cyc_end;
	frx_phase_gen u_phase
	(
		.clk(clk),
		.rst(rst),
		.phase_ff(phase),
		.cyc_end_ff(cyc_end)
	);

	// ==========================================
	// Decode
	logic [5:0] opc;
	logic dst_reg;
	logic is_copy;
	logic is_sub;
	logic is_swap;
	logic is_dirld;
	logic [2:0] dir_idx;
	logic exec;
	assign opc = instr_word[frx_pkg::OPC_HI:frx_pkg::OPC_LO];
	assign dst_reg = instr_word[frx_pkg::DST_BIT];
	assign is_copy = (opc == frx_pkg::OPC_COPY);
	assign is_sub = (opc == frx_pkg::OPC_SUB);
	assign is_swap = (opc == frx_pkg::OPC_SWAP);
	assign dir_idx = instr_word[2:0];
	assign is_dirld = (instr_word[13:3] == frx_pkg::DIRLD_PREFIX)
		&& (dir_idx >= frx_pkg::DIR_FIRST) && (dir_idx <= frx_pkg::DIR_LAST);
	// Execute once, on the last clock of the cycle
	assign exec = instr_valid && (phase == frx_pkg::PHASES);

	// ==========================================
	// Arithmetic
	logic [8:0] diff;
	logic [4:0] ldiff;
	logic [7:0] swapped;
	logic [7:0] result;
	assign diff = {1'b0, file_rdata} + {1'b0, ~acc_ff} + 9'h001;
	assign ldiff = {1'b0, file_rdata[3:0]} + {1'b0, ~acc_ff[3:0]} + 5'h01;
	assign swapped = {file_rdata[3:0], file_rdata[7:4]};
	// Result mux
	always_comb
	begin
		result = file_rdata;
		if (is_sub)
			result = diff[7:0];
		else if (is_swap)
			result = swapped;
	end

	// ==========================================
	// File address follows the instruction
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			file_addr_ff <= 7'h00;
		else
			file_addr_ff <= instr_word[6:0];
	end

	// File write-back, one clock per instruction cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			file_we_ff <= 1'b0;
			file_wdata_ff <= 8'h00;
		end
		else
		begin
			file_we_ff <= exec && dst_reg && (is_copy || is_sub || is_swap);
			file_wdata_ff <= result;
		end
	end

	// Accumulator
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			acc_ff <= frx_pkg::ACC_RESET;
		else if (exec && !dst_reg && (is_copy || is_sub || is_swap))
			acc_ff <= result;
	end

	// Flags: swap and load-direction leave them alone
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			flags_ff <= frx_pkg::FLAG_RESET;
		else if (exec && is_sub)
		begin
			flags_ff[frx_pkg::FLG_C] <= diff[8];
			flags_ff[frx_pkg::FLG_HB] <= ldiff[4];
			flags_ff[frx_pkg::FLG_Z] <= (diff[7:0] == 8'h00);
		end
		else if (exec && is_copy)
			flags_ff[frx_pkg::FLG_Z] <= (file_rdata == 8'h00);
	end

	// ==========================================
	// Direction latches, via opcode or direct access
	genvar g;
	generate
		for (g = 0; g < frx_pkg::DIR_COUNT; g++)
		begin : g_dir
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					dir_latch_ff[g*8 +: 8] <= frx_pkg::DIR_RESET;
				else if (exec && is_dirld && (dir_idx == frx_pkg::DIR_FIRST + 3'(g)))
					dir_latch_ff[g*8 +: 8] <= acc_ff;
				else if (dir_we && (dir_sel == 2'(g)))
					dir_latch_ff[g*8 +: 8] <= dir_wdata;
			end
		end
	endgenerate

	// Direct read port
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			dir_rdata_ff <= 8'h00;
		else if (dir_sel < 2'(frx_pkg::DIR_COUNT))
			dir_rdata_ff <= dir_latch_ff[dir_sel*8 +: 8];
		else
			dir_rdata_ff <= 8'h00;
	end

	// Cycle completion marker
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cycle_done_ff <= 1'b0;
		else
			cycle_done_ff <= exec;
	end

	// ==========================================
	// Checks
	chk_exec_period: assert property (@(posedge clk) disable iff (rst)
		exec |=> !exec ##1 !exec ##1 !exec) else $error("exec not once per four clocks");
	chk_cyc_end: assert property (@(posedge clk) disable iff (rst)
		cyc_end |-> phase == frx_pkg::PHASES) else $error("phase divider misaligned");
	chk_sub_acc: assert property (@(posedge clk) disable iff (rst)
		exec && is_sub && !dst_reg |=> acc_ff == $past(diff[7:0])) else $error("sub acc");
	chk_sub_carry: assert property (@(posedge clk) disable iff (rst)
		exec && is_sub |=> flags_ff[0] == ($past(file_rdata) >= $past(acc_ff)))
		else $error("carry wrong");
	chk_copy_zero: assert property (@(posedge clk) disable iff (rst)
		exec && is_copy |=> flags_ff[2] == ($past(file_rdata) == 8'h00))
		else $error("copy zero flag wrong");
	chk_swap_flags: assert property (@(posedge clk) disable iff (rst)
		exec && (is_swap || is_dirld) |=> $stable(flags_ff)) else $error("flags moved");
	chk_swap_write: assert property (@(posedge clk) disable iff (rst)
		exec && is_swap && dst_reg |=> file_we_ff
		&& file_wdata_ff == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
		else $error("swap write wrong");
	chk_acc_target: assert property (@(posedge clk) disable iff (rst)
		exec && !dst_reg |=> !file_we_ff) else $error("register written");
	chk_dir_load: assert property (@(posedge clk) disable iff (rst)
		exec && is_dirld && dir_idx == 3'h5 |=> dir_latch_ff[7:0] == $past(acc_ff))
		else $error("direction load wrong");
	chk_dir_direct: assert property (@(posedge clk) disable iff (rst)
		dir_we && dir_sel == 2'h1 && !(exec && is_dirld) |=> dir_latch_ff[15:8] == $past(dir_wdata))
		else $error("direct write wrong");
endmodule

/* File: verif/frx_datapath_tb.sv */
/*
 Self-checking bench for the file-register operation datapath.
 Assumes the package is compiled first and one instruction every four clocks.
*/
module frx_datapath_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [13:0] instr_word = 14'h0000;
	logic instr_valid = 1'b0;
	logic [6:0] file_addr_ff;
	logic [7:0] file_rdata;
	logic [7:0] file_wdata_ff;
	logic file_we_ff;
	logic [1:0] dir_sel = 2'h0;
	logic dir_we = 1'b0;
	logic [7:0] dir_wdata = 8'h00;
	logic [7:0] dir_rdata_ff;
	logic [7:0] acc_ff;
	logic [2:0] flags_ff;
	logic [23:0] dir_latch_ff;
	logic cycle_done_ff;
	logic [7:0] fm [0:127];
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	frx_datapath u_frx_datapath (.clk(clk), .rst(rst), .instr_word(instr_word),
		.instr_valid(instr_valid), .file_addr_ff(file_addr_ff), .file_rdata(file_rdata),
		.file_wdata_ff(file_wdata_ff), .file_we_ff(file_we_ff), .dir_sel(dir_sel),
		.dir_we(dir_we), .dir_wdata(dir_wdata), .dir_rdata_ff(dir_rdata_ff),
		.acc_ff(acc_ff), .flags_ff(flags_ff), .dir_latch_ff(dir_latch_ff),
		.cycle_done_ff(cycle_done_ff));
	// =====================================
	// Clock, file model and cycle limit
	always #12.5 clk = ~clk;
	assign file_rdata = fm[file_addr_ff];
	always @(posedge clk)
	begin
		if (file_we_ff)
			fm[file_addr_ff] <= file_wdata_ff;
		cyc <= cyc + 1;
		if (cyc == 1000)
		begin
			n_fail++;
			results();
		end
	end
	// =====================================
	// Tasks
	// Compare and count
	task chk(input string nm, input logic [23:0] s, input logic [23:0] e);
		checks_done++;
		if (s !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Build an instruction word
	function logic [13:0] op(input logic [5:0] o, input logic d, input logic [6:0] f);
		return {o, d, f};
	endfunction
	// Run one instruction cycle and check its outcome
	task ex(input logic [13:0] w, input logic [7:0] ea, input logic [2:0] ef,
		input logic ewe, input logic [7:0] ewd);
		int n;
		instr_word = w;
		instr_valid = 1'b1;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (cycle_done_ff !== 1'b1 && n < 8);
		chk("cycle_len", n, 4);
		chk("file_addr", file_addr_ff, w[6:0]);
		chk("acc", acc_ff, ea);
		chk("flags", flags_ff, ef);
		chk("file_we", file_we_ff, ewe);
		if (ewe)
			chk("file_wdata", file_wdata_ff, ewd);
	endtask
	// Direct latch write or read through the side port
	task dacc(input logic [1:0] s, input logic we, input logic [7:0] d);
		dir_sel = s;
		dir_we = we;
		dir_wdata = d;
		@(negedge clk);
		dir_we = 1'b0;
	endtask
	// Verdict
	task results();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// =====================================
	// Test sequence
	initial
	begin
		fm[7'h21] = 8'h00;
		fm[7'h22] = 8'h80;
		fm[7'h23] = 8'h02;
		fm[7'h24] = 8'h03;
		fm[7'h25] = 8'h02;
		fm[7'h26] = 8'h01;
		fm[7'h27] = 8'hA5;
		repeat (5) @(negedge clk);
		chk("latch_rst", dir_latch_ff, 24'hFFFFFF);
		rst = 1'b0;
		ex(op(frx_pkg::OPC_COPY, 0, 7'h21), 8'h00, 3'h4, 0, 8'h00);
		ex(op(frx_pkg::OPC_COPY, 1, 7'h22), 8'h00, 3'h0, 1, 8'h80);
		ex(op(frx_pkg::OPC_COPY, 0, 7'h23), 8'h02, 3'h0, 0, 8'h00);
		ex(op(frx_pkg::OPC_SUB, 1, 7'h24), 8'h02, 3'h3, 1, 8'h01);
		ex(op(frx_pkg::OPC_SUB, 1, 7'h26), 8'h02, 3'h0, 1, 8'hFF);
		ex(op(frx_pkg::OPC_SUB, 0, 7'h25), 8'h00, 3'h7, 0, 8'h00);
		ex(op(frx_pkg::OPC_SWAP, 0, 7'h27), 8'h5A, 3'h7, 0, 8'h00);
		ex(op(frx_pkg::OPC_SWAP, 1, 7'h27), 8'h5A, 3'h7, 1, 8'h5A);
		ex({frx_pkg::DIRLD_PREFIX, 3'h5}, 8'h5A, 3'h7, 0, 8'h00);
		chk("latches", dir_latch_ff, 24'hFFFF5A);
		ex({frx_pkg::DIRLD_PREFIX, 3'h4}, 8'h5A, 3'h7, 0, 8'h00);
		chk("latches", dir_latch_ff, 24'hFFFF5A);
		ex(op(frx_pkg::OPC_COPY, 0, 7'h22), 8'h80, 3'h3, 0, 8'h00);
		ex({frx_pkg::DIRLD_PREFIX, 3'h7}, 8'h80, 3'h3, 0, 8'h00);
		chk("latches", dir_latch_ff, 24'h80FF5A);
		ex(op(6'h3F, 1, 7'h22), 8'h80, 3'h3, 0, 8'h00);
		instr_valid = 1'b0;
		dacc(2'h1, 1, 8'h3C);
		chk("latches", dir_latch_ff, 24'h803C5A);
		dacc(2'h1, 0, 8'h00);
		chk("dir_rdata", dir_rdata_ff, 8'h3C);
		dacc(2'h2, 0, 8'h00);
		chk("dir_rdata", dir_rdata_ff, 8'h80);
		dacc(2'h3, 0, 8'h00);
		chk("dir_rdata", dir_rdata_ff, 8'h00);
		results();
	end
endmodule
